// >>> hess_dev.sv
`timescale 1ns/1ps
// Purpose: controller end: enable, setup and card-select logic
// Assumes: strap and switch pins are asynchronous, synchronised here
// Notes: mc_mode high selects the channel bus configuration
module hess_dev (
  input wire logic sys_clk,
  input wire logic rstn,
  // link
  hess_if.dev lk,
  // straps and switches
  input wire logic mc_mode,
  input wire logic [hess_pkg::SW_W-1:0] sw_pins,
  // status
  output logic full_en_r,
  output logic setup_r,
  output logic [7:0] mem_enable_r
);
  // ****************************************
  // synchronisers
  // ****************************************
  logic [4:0] s1_r, s2_r;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s1_r <= 5'h1_f;
      s2_r <= 5'h1_f;
    end else begin
      s1_r <= {lk.slot_setup_line_n, mc_mode, sw_pins};
      s2_r <= s1_r;
    end
  end
  logic slot_n, mc;
  logic [2:0] sw;
  assign slot_n = s2_r[4];
  assign mc = s2_r[3];
  // only two switches on mc: bit0 pin is the setup line there
  assign sw = mc ? {s2_r[2:1], 1'b0} : s2_r[2:0];

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] vid_r, vid_nxt, opa_r, opa_nxt, opb_r, opb_nxt;
  logic mcen_r, mcen_nxt, pcen_r, pcen_nxt, pcset_r, pcset_nxt, misc_r, misc_nxt;
  logic [2:0] ext_r, ext_nxt;
  logic [7:0] rd_nxt, rd_r;
  logic cs_nxt, cs_r, full_nxt, setup_nxt;
  logic selected, in_setup, id_hit, acc;

  always_comb begin
    // setup from per-slot line on mc, setup_and_enable_pc bit4 on pc
    in_setup = mc ? !slot_n : pcset_r;
    // switch compare only outside mc
    id_hit = mc ? 1'b1 : (ext_r == sw);
    // bus bit and video enable both needed
    full_nxt = (mc ? mcen_r : pcen_r) && vid_r[hess_pkg::BIT_VIDEO_EN] && id_hit;
    setup_nxt = in_setup;
    selected = full_en_r;
    vid_nxt = vid_r;
    opa_nxt = opa_r;
    opb_nxt = opb_r;
    mcen_nxt = mcen_r;
    pcen_nxt = pcen_r;
    pcset_nxt = pcset_r;
    misc_nxt = misc_r;
    ext_nxt = ext_r;
    rd_nxt = hess_pkg::RST_BYTE;
    cs_nxt = 1'b0;
    acc = lk.io_wr || lk.io_rd;
    if (acc) begin
      case (lk.io_addr)
        // id registers only here, only in setup
        hess_pkg::ADR_ID_VIDEO, hess_pkg::ADR_ID_OPT_A, hess_pkg::ADR_ID_OPT_B: begin
          if (in_setup) begin
            cs_nxt = 1'b1;
            if (lk.io_wr) begin
              if (lk.io_addr == hess_pkg::ADR_ID_VIDEO) vid_nxt = lk.io_wdata;
              else if (lk.io_addr == hess_pkg::ADR_ID_OPT_A) opa_nxt = lk.io_wdata;
              else opb_nxt = lk.io_wdata;
            end else begin
              rd_nxt = (lk.io_addr == hess_pkg::ADR_ID_VIDEO) ? vid_r :
                       (lk.io_addr == hess_pkg::ADR_ID_OPT_A) ? opa_r : opb_r;
            end
          end
        end
        hess_pkg::ADR_SUB_EN_MC: begin
          if (mc) begin
            if (lk.io_wr) begin
              mcen_nxt = lk.io_wdata[hess_pkg::BIT_MC_EN];
              cs_nxt = misc_r;
            end else if (misc_r) begin
              cs_nxt = 1'b1;
              rd_nxt = {7'h0_0, mcen_r};
            end
          end
        end
        hess_pkg::ADR_SETUP_EN_PC: begin
          if (!mc) begin
            cs_nxt = 1'b1;
            // only bits 3 and 4 act, no rom paging
            if (lk.io_wr) begin
              pcen_nxt = lk.io_wdata[hess_pkg::BIT_PC_EN];
              pcset_nxt = lk.io_wdata[hess_pkg::BIT_PC_SETUP];
            end else begin
              rd_nxt = {3'h0, pcset_r, pcen_r, 3'h0};
            end
          end
        end
        hess_pkg::ADR_EXT_ENABLE: begin
          // id write always taken so an unselected card can be reselected
          if (lk.io_wr) ext_nxt = lk.io_wdata[2:0];
          else if (selected) rd_nxt = {5'h0_0, ext_r};
          cs_nxt = selected;
        end
        hess_pkg::ADR_SWITCH_READBACK: begin
          cs_nxt = selected;
          if (lk.io_rd && selected) rd_nxt = {5'h0_0, sw};
        end
        hess_pkg::ADR_MISC_IFACE: begin
          cs_nxt = selected;
          if (selected) begin
            if (lk.io_wr) misc_nxt = lk.io_wdata[hess_pkg::BIT_MISC_RD3C3];
            else rd_nxt = {7'h0_0, misc_r};
          end
        end
        default: cs_nxt = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      vid_r <= hess_pkg::RST_BYTE;
      opa_r <= hess_pkg::RST_BYTE;
      opb_r <= hess_pkg::RST_BYTE;
      mcen_r <= 1'b0;
      pcen_r <= 1'b0;
      pcset_r <= 1'b0;
      misc_r <= 1'b0;
      ext_r <= 3'h0;
      rd_r <= hess_pkg::RST_BYTE;
      cs_r <= 1'b0;
      full_en_r <= 1'b0;
      setup_r <= 1'b0;
      mem_enable_r <= hess_pkg::RST_BYTE;
    end else begin
      vid_r <= vid_nxt;
      opa_r <= opa_nxt;
      opb_r <= opb_nxt;
      mcen_r <= mcen_nxt;
      pcen_r <= pcen_nxt;
      pcset_r <= pcset_nxt;
      misc_r <= misc_nxt;
      ext_r <= ext_nxt;
      rd_r <= rd_nxt;
      cs_r <= cs_nxt;
      full_en_r <= full_nxt;
      setup_r <= setup_nxt;
      mem_enable_r <= {7'h0_0, full_nxt};
    end
  end
  assign lk.io_rdata = rd_r;
  assign lk.card_sel = cs_r;
endmodule

// >>> hess_host.sv
`timescale 1ns/1ps
// Purpose: host end: issues I/O cycles and runs the enable sequence
// Assumes: software port with read data one cycle after the strobe
// Notes: bring-up follows the bus selected by mc_mode
module hess_host (
  input wire logic sys_clk,
  input wire logic rstn,
  // software port
  input wire logic [15:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata_r,
  // configuration
  input wire logic mc_mode,
  // link
  hess_if.host lk
);
  typedef enum logic [2:0] {IDLE, S_IO, S_EN, S_SET, S_HOLD, S_VID, S_UNSET, S_WAIT} st_e;
  st_e st_r, st_nxt;
  logic [15:0] ioa_r, ioa_nxt, adr_r, adr_nxt;
  logic [7:0] iow_r, iow_nxt, wd_r, wd_nxt, last_r, last_nxt;
  logic wr_r, wr_nxt, rdq_r, rdq_nxt, setn_r, setn_nxt, busy_r, busy_nxt, cs_r, cs_nxt;
  logic [31:0] rdata_nxt;
  logic wrd_r, wrd_nxt, rdd_r, rdd_nxt, mc_s1_r, mc_s2_r, mc;
  assign mc = mc_s2_r;

  always_comb begin
    st_nxt = st_r;
    ioa_nxt = ioa_r;
    iow_nxt = iow_r;
    adr_nxt = adr_r;
    wd_nxt = wd_r;
    wr_nxt = 1'b0;
    rdq_nxt = 1'b0;
    setn_nxt = setn_r;
    busy_nxt = busy_r;
    last_nxt = last_r;
    cs_nxt = cs_r;
    rdata_nxt = 32'h0000_0000;
    wrd_nxt = wr_r;
    rdd_nxt = rdq_r;
    // answer stands the cycle after the strobe, so take it one edge later
    if (rdd_r) begin
      last_nxt = lk.io_rdata;
      cs_nxt = lk.card_sel;
    end else if (wrd_r) begin
      cs_nxt = lk.card_sel;
    end
    if (wr && addr == hess_pkg::ADR_HOST_IOADR) adr_nxt = wdata[15:0];
    if (wr && addr == hess_pkg::ADR_HOST_WDATA) wd_nxt = wdata[7:0];
    if (rd) begin
      case (addr)
        hess_pkg::ADR_HOST_STAT: rdata_nxt = {22'h0, cs_r, busy_r, last_r};
        hess_pkg::ADR_HOST_RDATA: rdata_nxt = {24'h00_0000, last_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
    case (st_r)
      IDLE: begin
        busy_nxt = 1'b0;
        if (wr && addr == hess_pkg::ADR_HOST_CMD) begin
          case (wdata[7:0])
            hess_pkg::CMD_IO_WR: begin
              ioa_nxt = adr_r;
              iow_nxt = wd_r;
              wr_nxt = 1'b1;
              st_nxt = S_IO;
              busy_nxt = 1'b1;
            end
            hess_pkg::CMD_IO_RD: begin
              ioa_nxt = adr_r;
              rdq_nxt = 1'b1;
              st_nxt = S_IO;
              busy_nxt = 1'b1;
            end
            hess_pkg::CMD_SETUP_ON: begin
              setn_nxt = 1'b0;
              st_nxt = S_IO;
              busy_nxt = 1'b1;
            end
            hess_pkg::CMD_SETUP_OFF: begin
              setn_nxt = 1'b1;
              st_nxt = S_IO;
              busy_nxt = 1'b1;
            end
            hess_pkg::CMD_BRINGUP: begin
              st_nxt = S_EN;
              busy_nxt = 1'b1;
            end
            default: busy_nxt = 1'b0;
          endcase
        end
      end
      // busy covers the answer and the far end's setup line synchronisers
      S_IO: st_nxt = S_WAIT;
      // bring-up order: enable, setup, video enable, leave setup
      S_EN: begin
        wr_nxt = 1'b1;
        ioa_nxt = mc ? hess_pkg::ADR_SUB_EN_MC : hess_pkg::ADR_SETUP_EN_PC;
        iow_nxt = mc ? 8'h01 : 8'h08;
        st_nxt = S_SET;
      end
      S_SET: begin
        // mc: slot line low stands for port 94h bit5 set
        if (mc) setn_nxt = 1'b0;
        else begin
          wr_nxt = 1'b1;
          ioa_nxt = hess_pkg::ADR_SETUP_EN_PC;
          iow_nxt = 8'h18;
        end
        st_nxt = S_HOLD;
      end
      // far end sees the setup line two edges late
      S_HOLD: st_nxt = S_VID;
      S_VID: begin
        wr_nxt = 1'b1;
        ioa_nxt = hess_pkg::ADR_ID_VIDEO;
        iow_nxt = 8'h01;
        st_nxt = S_UNSET;
      end
      S_UNSET: begin
        if (mc) setn_nxt = 1'b1;
        else begin
          wr_nxt = 1'b1;
          ioa_nxt = hess_pkg::ADR_SETUP_EN_PC;
          iow_nxt = 8'h08;
        end
        st_nxt = S_WAIT;
      end
      S_WAIT: st_nxt = IDLE;
      default: st_nxt = IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= IDLE;
      ioa_r <= 16'h0000;
      iow_r <= 8'h00;
      adr_r <= 16'h0000;
      wd_r <= 8'h00;
      wr_r <= 1'b0;
      rdq_r <= 1'b0;
      setn_r <= 1'b1;
      busy_r <= 1'b0;
      last_r <= 8'h00;
      cs_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      wrd_r <= 1'b0;
      rdd_r <= 1'b0;
      mc_s1_r <= 1'b0;
      mc_s2_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      ioa_r <= ioa_nxt;
      iow_r <= iow_nxt;
      adr_r <= adr_nxt;
      wd_r <= wd_nxt;
      wr_r <= wr_nxt;
      rdq_r <= rdq_nxt;
      setn_r <= setn_nxt;
      busy_r <= busy_nxt;
      last_r <= last_nxt;
      cs_r <= cs_nxt;
      rdata_r <= rdata_nxt;
      wrd_r <= wrd_nxt;
      rdd_r <= rdd_nxt;
      mc_s1_r <= mc_mode;
      mc_s2_r <= mc_s1_r;
    end
  end
  assign lk.io_addr = ioa_r;
  assign lk.io_wdata = iow_r;
  assign lk.io_wr = wr_r;
  assign lk.io_rd = rdq_r;
  assign lk.slot_setup_line_n = setn_r;
endmodule

// >>> hess_if.sv
`timescale 1ns/1ps
// Purpose: I/O cycle link between host and controller
// Assumes: one clock; host drives strobes one cycle
// Notes: card_sel and io_rdata answer one cycle after a strobe
interface hess_if;
  logic [15:0] io_addr;
  logic [7:0] io_wdata;
  logic io_wr;
  logic io_rd;
  logic slot_setup_line_n;
  logic [7:0] io_rdata;
  logic card_sel;
  modport host (output io_addr, io_wdata, io_wr, io_rd, slot_setup_line_n, input io_rdata, card_sel);
  modport dev (input io_addr, io_wdata, io_wr, io_rd, slot_setup_line_n, output io_rdata, card_sel);
endinterface

// >>> hess_pkg.sv
// Purpose: shared constants for the host enable / setup / card-select pair
// Assumes: byte-wide I/O cycles on a 16-bit I/O address, one clock domain
// Notes: none
package hess_pkg;
  localparam logic [15:0] ADR_ID_VIDEO = 16'h0102;
  localparam logic [15:0] ADR_ID_OPT_A = 16'h0103;
  localparam logic [15:0] ADR_ID_OPT_B = 16'h0104;
  localparam logic [15:0] ADR_SUB_EN_MC = 16'h03c3;
  localparam logic [15:0] ADR_SETUP_EN_PC = 16'h46e8;
  // extension registers, index chosen here
  localparam logic [15:0] ADR_SWITCH_READBACK = 16'h03d1;
  localparam logic [15:0] ADR_EXT_ENABLE = 16'h03d2;
  localparam logic [15:0] ADR_MISC_IFACE = 16'h03d3;
  localparam int BIT_VIDEO_EN = 0;
  localparam int BIT_MC_EN = 0;
  localparam int BIT_PC_EN = 3;
  localparam int BIT_PC_SETUP = 4;
  localparam int BIT_MISC_RD3C3 = 0;
  localparam int BIT_SLOT_SETUP = 5;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int SW_W = 3;
  // host order slots
  localparam logic [15:0] ADR_HOST_CMD = 16'h0000;
  localparam logic [15:0] ADR_HOST_STAT = 16'h0004;
  localparam logic [15:0] ADR_HOST_IOADR = 16'h0008;
  localparam logic [15:0] ADR_HOST_WDATA = 16'h000c;
  localparam logic [15:0] ADR_HOST_RDATA = 16'h0010;
  localparam logic [7:0] CMD_IO_WR = 8'h01;
  localparam logic [7:0] CMD_IO_RD = 8'h02;
  localparam logic [7:0] CMD_BRINGUP = 8'h03;
  localparam logic [7:0] CMD_SETUP_ON = 8'h04;
  localparam logic [7:0] CMD_SETUP_OFF = 8'h05;
endpackage

// >>> hess_sva.sv
`timescale 1ns/1ps
// Purpose: link checker for the host enable and card select pair
// Assumes: one clock, asynchronous active-low reset
// Notes: pc port bits tracked from acknowledged writes
module hess_sva (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // link
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic slot_setup_line_n,
  input wire logic [7:0] io_rdata,
  input wire logic card_sel
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic wr_r;
  logic pc_en_r;
  logic pc_set_r;
  logic misc_r;
  logic [15:0] adr_r;
  logic [7:0] dat_r;
  logic pc_wr_prev;
  assign pc_wr_prev = wr_r && adr_r == hess_pkg::ADR_SETUP_EN_PC;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_r <= 1'b0;
      adr_r <= 16'h0000;
      dat_r <= 8'h00;
      pc_en_r <= 1'b0;
      pc_set_r <= 1'b0;
      misc_r <= 1'b0;
    end else begin
      wr_r <= io_wr;
      adr_r <= io_addr;
      dat_r <= io_wdata;
      if (card_sel && pc_wr_prev) begin
        pc_en_r <= dat_r[hess_pkg::BIT_PC_EN];
        pc_set_r <= dat_r[hess_pkg::BIT_PC_SETUP];
      end
      if (card_sel && wr_r && adr_r == hess_pkg::ADR_MISC_IFACE) begin
        misc_r <= dat_r[hess_pkg::BIT_MISC_RD3C3];
      end
    end
  end
  // ****
  // assertions
  // ****
  sequence s_acc(a);
    (io_wr || io_rd) && io_addr == a;
  endsequence
  sequence s_pc_rd;
    card_sel && $past(io_rd) && $past(io_addr) == hess_pkg::ADR_SETUP_EN_PC;
  endsequence
  a_sel_cause: assert property (card_sel |-> $past(io_wr || io_rd))
    else $error("card select without a strobe");
  a_refused_zero: assert property ($past(io_rd) && !card_sel |-> io_rdata == 8'h00)
    else $error("refused read returned data");
  a_id_window: assert property ((io_wr || io_rd) && io_addr inside {16'h0100, 16'h0101, 16'h0105} |=> !card_sel)
    else $error("id address outside window answered");
  a_no_paging: assert property (s_pc_rd |-> (io_rdata & 8'he7) == 8'h00)
    else $error("pc port extra bits read back");
  a_pc_bits: assert property (s_pc_rd |-> io_rdata[3] == pc_en_r && io_rdata[4] == pc_set_r)
    else $error("pc port bits wrong");
  a_id_no_setup: assert property (s_acc(hess_pkg::ADR_ID_VIDEO) ##0 (!pc_set_r && !pc_wr_prev && slot_setup_line_n
    && $past(slot_setup_line_n) && $past(slot_setup_line_n, 2)) |=> !card_sel)
    else $error("id register answered outside setup");
  a_id_in_setup: assert property (s_acc(hess_pkg::ADR_ID_VIDEO) ##0 (pc_set_r && pc_en_r && !pc_wr_prev) |=> card_sel)
    else $error("id register refused in setup");
  a_write_only: assert property (io_rd && io_addr == hess_pkg::ADR_SUB_EN_MC && !misc_r
    && !(wr_r && adr_r == hess_pkg::ADR_MISC_IFACE) |=> !card_sel)
    else $error("write-only port answered a read");
  a_reset_idle: assert property ($rose(rstn) |-> slot_setup_line_n)
    else $error("setup line low after reset");
endmodule

// >>> host_enable_setup_select_tb.sv
`timescale 1ns/1ps
// Purpose: bench for host enable, setup and card select pair
// Assumes: host status bits 9:0 are card select, busy, last byte
// Notes: expected enable worked out from integer model state
module host_enable_setup_select_tb;
  logic sys_clk = 0, rstn = 0, wr = 0, rd = 0, mc_mode = 0;
  logic [15:0] addr = 16'h0000;
  logic [31:0] wdata = 32'h0000_0000, rdata_r, d;
  logic [2:0] sw_pins = 3'h0;
  logic full_en_r, setup_r;
  logic [7:0] mem_enable_r, rv;
  int miscompares = 0, n_tests = 0, pc_en, vid, mc_en, eid, sw;
  hess_if lk ();
  hess_dev i_hess_dev (.sys_clk(sys_clk), .rstn(rstn), .lk(lk), .mc_mode(mc_mode), .sw_pins(sw_pins),
    .full_en_r(full_en_r), .setup_r(setup_r), .mem_enable_r(mem_enable_r));
  hess_host i_hess_host (.sys_clk(sys_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_r(rdata_r), .mc_mode(mc_mode), .lk(lk));
  hess_sva i_hess_sva (.sys_clk(sys_clk), .rstn(rstn), .io_addr(lk.io_addr), .io_wdata(lk.io_wdata),
    .io_wr(lk.io_wr), .io_rd(lk.io_rd), .slot_setup_line_n(lk.slot_setup_line_n), .io_rdata(lk.io_rdata),
    .card_sel(lk.card_sel));
  initial forever #12.5 sys_clk = ~sys_clk;
  // ****
  // tasks
  // ****
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (exp !== got) begin
      miscompares++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  function automatic logic exp_full();
    return mc_mode ? (mc_en != 0 && vid != 0) : (pc_en != 0 && vid != 0 && eid == sw);
  endfunction
  task automatic sw_wr(logic [15:0] a, logic [31:0] v);
    @(posedge sys_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic sw_rd(logic [15:0] a);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata_r;
  endtask
  task automatic run(logic [7:0] cmd);
    int i;
    sw_wr(hess_pkg::ADR_HOST_CMD, {24'h00_0000, cmd});
    for (i = 0; i < 40; i++) begin
      sw_rd(hess_pkg::ADR_HOST_STAT);
      if (d[8] === 1'b0) break;
    end
    if (i == 40) begin
      miscompares++;
      tally_and_finish();
    end
    chk("full_en", exp_full(), full_en_r);
    chk("mem_en", exp_full(), mem_enable_r);
  endtask
  task automatic io(logic [15:0] a, logic [7:0] v, logic w);
    sw_wr(hess_pkg::ADR_HOST_IOADR, {16'h0000, a});
    sw_wr(hess_pkg::ADR_HOST_WDATA, {24'h00_0000, v});
    run(w ? hess_pkg::CMD_IO_WR : hess_pkg::CMD_IO_RD);
  endtask
  task automatic do_reset(logic m);
    @(posedge sys_clk);
    rstn <= 1'b0;
    mc_mode <= m;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    pc_en = 0;
    vid = 0;
    mc_en = 0;
    eid = 0;
    chk("full_en", 0, full_en_r);
    chk("setup", 0, setup_r);
    chk("line", 1, lk.slot_setup_line_n);
  endtask
  // ****
  // sequence
  // ****
  initial begin
    void'($urandom(32'hf296));
    sw = $urandom % 8;
    sw_pins <= sw[2:0];
    do_reset(1'b0);
    io(hess_pkg::ADR_ID_VIDEO, 8'h01, 1'b1);
    chk("id out of setup", 0, d[9]);
    eid = sw;
    io(hess_pkg::ADR_EXT_ENABLE, eid[7:0], 1'b1);
    pc_en = 1;
    vid = 1;
    run(hess_pkg::CMD_BRINGUP);
    chk("setup", 0, setup_r);
    io(hess_pkg::ADR_SETUP_EN_PC, 8'hff, 1'b1);
    chk("setup", 1, setup_r);
    io(hess_pkg::ADR_SETUP_EN_PC, 8'h00, 1'b0);
    chk("pc bits", 8'h18, d[7:0]);
    io(hess_pkg::ADR_SETUP_EN_PC, 8'h08, 1'b1);
    io(16'h0100, 8'h00, 1'b0);
    chk("unmapped", 0, d[9]);
    io(hess_pkg::ADR_SWITCH_READBACK, 8'h00, 1'b0);
    chk("switches", sw, d[2:0]);
    eid = sw ^ (1 + $urandom % 7);
    io(hess_pkg::ADR_EXT_ENABLE, eid[7:0], 1'b1);
    eid = sw;
    io(hess_pkg::ADR_EXT_ENABLE, eid[7:0], 1'b1);
    pc_en = 0;
    io(hess_pkg::ADR_SETUP_EN_PC, 8'h00, 1'b1);
    $display("pc bus tests done");
    do_reset(1'b1);
    eid = sw ^ 2;
    io(hess_pkg::ADR_EXT_ENABLE, eid[7:0], 1'b1);
    mc_en = 1;
    vid = 1;
    run(hess_pkg::CMD_BRINGUP);
    io(hess_pkg::ADR_SWITCH_READBACK, 8'h00, 1'b0);
    chk("two switches", sw & 6, d[2:0]);
    io(hess_pkg::ADR_SUB_EN_MC, 8'h00, 1'b0);
    chk("write only", 0, d[9]);
    io(hess_pkg::ADR_MISC_IFACE, 8'h01, 1'b1);
    io(hess_pkg::ADR_SUB_EN_MC, 8'h00, 1'b0);
    chk("readable", 32'h201, d[9:0]);
    run(hess_pkg::CMD_SETUP_ON);
    chk("setup", 1, setup_r);
    io(hess_pkg::ADR_ID_VIDEO, 8'h00, 1'b0);
    chk("video enable", 32'h201, d[9:0]);
    rv = 8'($urandom);
    io(hess_pkg::ADR_ID_OPT_A, rv, 1'b1);
    io(hess_pkg::ADR_ID_OPT_A, 8'h00, 1'b0);
    chk("option a", {22'h0, 2'b10, rv}, d);
    sw_rd(hess_pkg::ADR_HOST_RDATA);
    chk("read data port", {24'h00_0000, rv}, d);
    io(hess_pkg::ADR_ID_OPT_B, ~rv, 1'b1);
    io(hess_pkg::ADR_ID_OPT_B, 8'h00, 1'b0);
    chk("option b", {22'h0, 2'b10, ~rv}, d);
    io(16'h0105, 8'h00, 1'b0);
    chk("past window", 0, d[9]);
    run(hess_pkg::CMD_SETUP_OFF);
    chk("setup", 0, setup_r);
    mc_en = 0;
    io(hess_pkg::ADR_SUB_EN_MC, 8'h00, 1'b1);
    chk("mc write ack", 1, d[9]);
    io(hess_pkg::ADR_MISC_IFACE, 8'h00, 1'b0);
    chk("disabled", 0, d[9]);
    $display("channel bus tests done");
    tally_and_finish();
  end
endmodule
